//--- core/uvf_supervisor.sv
// Supervisor top: alarm relays, self-test, fault latch, display and registers
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module uvf_supervisor
#(
    parameter int NUM_DET  = uvf_pkg::NUM_DET_MAX,
    parameter int WIN_CYC  = uvf_pkg::WIN_CYC,
    parameter int TEST_CYC = uvf_pkg::TEST_CYC
)
(
    input  wire logic               clk_i,
    input  wire logic               rstn_i,
    input  wire logic [NUM_DET-1:0] det_pulse_i,
    input  wire logic               sel_btn_i,
    input  wire logic               test_btn_i,
    input  wire logic [3:0]         reg_addr_i,
    input  wire logic [15:0]        reg_wdata_i,
    input  wire logic               reg_wr_i,
    input  wire logic               reg_rd_i,
    output logic      [15:0]        reg_rdata_o,
    output logic      [NUM_DET-1:0] test_lamp_o,
    output logic                    inst_relay_o,
    output logic                    timed_relay_o,
    output logic                    fault_relay_o,
    output logic      [3:0]         disp_right_o,
    output logic      [7:0]         disp_left_o,
    output logic                    irq_o
);
    initial
    begin
        if (NUM_DET < 1 || NUM_DET > uvf_pkg::NUM_DET_MAX)
            $error("NUM_DET out of range");
        if (WIN_CYC < 2 || TEST_CYC < 2 || TEST_CYC >= WIN_CYC)
            $error("bad timing counts");
    end

    // Pin synchronisers
    logic [NUM_DET-1:0] pls_s1_r, pls_s2_r, pls_s3_r;
    logic [1:0]         btn_s1_r, btn_s2_r, btn_s3_r;
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            pls_s1_r <= '0;
            pls_s2_r <= '0;
            pls_s3_r <= '0;
            btn_s1_r <= 2'b00;
            btn_s2_r <= 2'b00;
            btn_s3_r <= 2'b00;
        end
        else
        begin
            pls_s1_r <= det_pulse_i;
            pls_s2_r <= pls_s1_r;
            pls_s3_r <= pls_s2_r;
            btn_s1_r <= {test_btn_i, sel_btn_i};
            btn_s2_r <= btn_s1_r;
            btn_s3_r <= btn_s2_r;
        end
    end
    wire logic [NUM_DET-1:0] pls_rise = pls_s2_r & ~pls_s3_r;
    wire logic               sel_rise = btn_s2_r[0] & ~btn_s3_r[0];
    wire logic               man_test = btn_s2_r[1];

    // Registers
    logic [7:0]             ctrl_r;
    logic [15:0]            delay_r;
    logic [8:0]             fltin_r;
    logic [uvf_pkg::IRQ_W-1:0] irq_st_r, irq_msk_r, irq_ev;
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            ctrl_r    <= uvf_pkg::CTRL_RST;
            delay_r   <= uvf_pkg::DELAY_RST;
            fltin_r   <= 9'h000;
            irq_msk_r <= '0;
        end
        else if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                uvf_pkg::REG_CTRL:   ctrl_r    <= reg_wdata_i[7:0];
                uvf_pkg::REG_DELAY:  delay_r   <= reg_wdata_i;
                uvf_pkg::REG_FLTIN:  fltin_r   <= reg_wdata_i[8:0];
                uvf_pkg::REG_IRQMSK: irq_msk_r <= reg_wdata_i[uvf_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end
    wire logic       bypass = ctrl_r[uvf_pkg::CTRL_BYPASS];
    wire logic       manual = ctrl_r[uvf_pkg::CTRL_MANUAL] | man_test;
    wire logic [2:0] ndet_m1 = ctrl_r[uvf_pkg::CTRL_NDET_LSB +: 3];

    // Threshold select
    logic [7:0] thr;
    always_comb
    begin
        unique case (ctrl_r[uvf_pkg::CTRL_THR_LSB +: 2])
            2'd0: thr = uvf_pkg::THR_0;
            2'd1: thr = uvf_pkg::THR_1;
            2'd2: thr = uvf_pkg::THR_2;
            2'd3: thr = uvf_pkg::THR_3;
        endcase
    end

    // One-second window and test-slot enable
    logic [31:0] win_cnt_r;
    logic        win;
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            win_cnt_r <= 32'h0;
        else if (win_cnt_r == 32'(WIN_CYC - 1))
            win_cnt_r <= 32'h0;
        else
            win_cnt_r <= win_cnt_r + 32'h1;
    end
    assign win = win_cnt_r == 32'(WIN_CYC - 1);

    // Channels
    logic [NUM_DET-1:0] over, spur, seen, active;
    genvar g;
    generate
        for (g = 0; g < NUM_DET; g++)
        begin : g_ch
            uvf_rate_if rif ();
            assign rif.win   = win;
            assign rif.thr   = thr;
            assign rif.pulse = pls_rise[g];
            assign over[g]   = rif.over;
            assign spur[g]   = rif.spur;
            assign seen[g]   = rif.seen;
            assign active[g] = 3'(g) <= ndet_m1;
            uvf_rate_chan u_ch
            (
                .clk_i  (clk_i),
                .rstn_i (rstn_i),
                .rif    (rif)
            );
        end
    endgenerate

    // Self-test: one detector per window, lamp on during the first slot
    logic [2:0]         tst_idx_r;
    logic [NUM_DET-1:0] tst_mask_r;
    logic [NUM_DET-1:0] ovr_keep_r;
    logic [NUM_DET-1:0] ovr_eff;
    logic [NUM_DET-1:0] blind_r;
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            tst_idx_r <= 3'd0;
        else if (manual && sel_rise)
            tst_idx_r <= (tst_idx_r >= ndet_m1) ? 3'd0 : tst_idx_r + 3'd1;
        else if (!manual && win)
            tst_idx_r <= (tst_idx_r >= ndet_m1) ? 3'd0 : tst_idx_r + 3'd1;
    end
    // Channel lit in the window just closed; its verdicts are not trusted for the window that follows
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            tst_mask_r <= '0;
        else if (win)
            for (int i = 0; i < NUM_DET; i++)
                tst_mask_r[i] <= !manual && 3'(i) == tst_idx_r;
    end
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            test_lamp_o <= '0;
        else
            for (int i = 0; i < NUM_DET; i++)
                test_lamp_o[i] <= (3'(i) == tst_idx_r) && (manual ? man_test : win_cnt_r < 32'(TEST_CYC));
    end
    // A tested detector that stays dark is blind
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            blind_r <= '0;
        else if (bypass)
            blind_r <= '0;
        else if (win && !manual)
            for (int i = 0; i < NUM_DET; i++)
                if (3'(i) == tst_idx_r && active[i] && !seen[i])
                    blind_r[i] <= 1'b1;
    end

    // Alarms: automatic self-test windows never reach the relays; manual test windows are not masked
    // A lit channel repeats its last trusted verdict, so the lamp neither raises nor drops an alarm
    assign ovr_eff = (over & ~tst_mask_r) | (ovr_keep_r & tst_mask_r);
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            ovr_keep_r <= '0;
        else
            ovr_keep_r <= ovr_eff;
    end
    wire logic alarm = |(ovr_eff & active);
    logic [15:0] dly_cnt_r;
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            dly_cnt_r <= 16'h0;
        else if (!alarm)
            dly_cnt_r <= 16'h0;
        else if (win && dly_cnt_r != 16'hFFFF)
            dly_cnt_r <= dly_cnt_r + 16'h1;
    end
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            inst_relay_o  <= 1'b0;
            timed_relay_o <= 1'b0;
        end
        else
        begin
            inst_relay_o  <= alarm;
            timed_relay_o <= alarm && dly_cnt_r >= delay_r;
        end
    end

    // Fault sources; external inputs in fault-input register bits 1,3..8
    logic [3:0] fcode;
    logic       fany;
    always_comb
    begin
        fany  = 1'b1;
        fcode = uvf_pkg::FC_BLANK;
        if (|(spur & active & ~tst_mask_r))
            fcode = uvf_pkg::FC_SPUR;
        else if (fltin_r[1])
            fcode = uvf_pkg::FC_DCPWR;
        else if (|blind_r)
            fcode = uvf_pkg::FC_SENS;
        else if (fltin_r[3])
            fcode = uvf_pkg::FC_MON;
        else if (fltin_r[4])
            fcode = uvf_pkg::FC_LEADC;
        else if (fltin_r[5])
            fcode = uvf_pkg::FC_LEADB;
        else if (fltin_r[6])
            fcode = uvf_pkg::FC_LEADA;
        else if (fltin_r[7])
            fcode = uvf_pkg::FC_COMP;
        else if (bypass)
            fcode = uvf_pkg::FC_INHIB;
        else if (fltin_r[8])
            fcode = uvf_pkg::FC_BLANK;
        else
            fany = 1'b0;
    end

    // First-fault latch, released only by bypass
    logic       flt_lat_r;
    logic [3:0] flt_code_r;
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            flt_lat_r  <= 1'b0;
            flt_code_r <= uvf_pkg::FC_BLANK;
        end
        else if (bypass)
        begin
            flt_lat_r  <= 1'b1;
            flt_code_r <= uvf_pkg::FC_INHIB;
        end
        else if (!flt_lat_r && fany)
        begin
            flt_lat_r  <= 1'b1;
            flt_code_r <= fcode;
        end
        else if (flt_lat_r && flt_code_r == uvf_pkg::FC_INHIB)
        begin
            flt_lat_r  <= fany;
            flt_code_r <= fany ? fcode : uvf_pkg::FC_BLANK;
        end
    end

    // Relay and right digit updated by the same edge; the left digit's blind mask follows one edge later
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            fault_relay_o <= 1'b0;
            disp_right_o  <= uvf_pkg::FC_BLANK;
            disp_left_o   <= 8'h00;
        end
        else
        begin
            fault_relay_o <= !(fany || flt_lat_r);
            if (manual)
            begin
                disp_right_o <= {1'b0, tst_idx_r};
                disp_left_o  <= 8'h00;
            end
            else
            begin
                disp_right_o <= flt_lat_r ? flt_code_r : (fany ? fcode : uvf_pkg::FC_BLANK);
                // Left digit only carries the blind mask, or the detector count less one while bypassed
                disp_left_o  <= (flt_code_r == uvf_pkg::FC_SENS && flt_lat_r) ? 8'(blind_r)
                              : bypass ? 8'(ndet_m1) : 8'h00;
            end
        end
    end

    // Interrupts: set wins over write-one clear
    assign irq_ev = {fany, timed_relay_o, inst_relay_o};
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            irq_st_r <= '0;
        else
            irq_st_r <= irq_ev | (irq_st_r & ~((reg_wr_i && reg_addr_i == uvf_pkg::REG_IRQST)
                        ? reg_wdata_i[uvf_pkg::IRQ_W-1:0] : '0));
    end
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(irq_ev | (irq_st_r & irq_msk_r)) & |((irq_ev | irq_st_r) & irq_msk_r);
    end

    // Read port
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            reg_rdata_o <= 16'h0000;
        else if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                uvf_pkg::REG_CTRL:   reg_rdata_o <= {8'h00, ctrl_r};
                uvf_pkg::REG_STAT:   reg_rdata_o <= {fault_relay_o, timed_relay_o, inst_relay_o, flt_lat_r,
                                                     flt_code_r, 8'(blind_r)};
                uvf_pkg::REG_IRQST:  reg_rdata_o <= 16'(irq_st_r);
                uvf_pkg::REG_IRQMSK: reg_rdata_o <= 16'(irq_msk_r);
                uvf_pkg::REG_DELAY:  reg_rdata_o <= delay_r;
                uvf_pkg::REG_FLTIN:  reg_rdata_o <= {7'h00, fltin_r};
                uvf_pkg::REG_DISP:   reg_rdata_o <= {4'h0, disp_right_o, disp_left_o};
                default:             reg_rdata_o <= 16'h0000;
            endcase
        end
        else
            reg_rdata_o <= 16'h0000;
    end

    // Checks
    fault_relay_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        fany |=> !fault_relay_o) else $error("fault relay stayed energized");
    same_edge_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (!manual && $fell(fault_relay_o)) |-> disp_right_o != uvf_pkg::FC_BLANK || fltin_r[8])
        else $error("code not shown with fault");
    inst_alarm_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        alarm |=> inst_relay_o) else $error("instant relay late");
    timed_open_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !alarm |=> !timed_relay_o) else $error("timed relay closed without alarm");
    sequence timed_due_s;
        alarm && dly_cnt_r >= delay_r;
    endsequence
    timed_close_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        timed_due_s |=> timed_relay_o) else $error("timed relay missed");
    latch_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (flt_lat_r && !bypass && flt_code_r != uvf_pkg::FC_INHIB) |=> $stable(flt_code_r))
        else $error("latched code changed");
    selftest_quiet_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ((over & active) == tst_mask_r && !(|(ovr_keep_r & tst_mask_r))) |=> !inst_relay_o)
        else $error("self test reached relay");
    manual_disp_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        manual |=> disp_right_o == {1'b0, $past(tst_idx_r)}) else $error("test number not shown");
    left_blank_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (!manual && !bypass && !(flt_lat_r && flt_code_r == uvf_pkg::FC_SENS)) |=> disp_left_o == 8'h00)
        else $error("left digit shown");
    spur_code_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (!flt_lat_r && !bypass && |(spur & active & ~tst_mask_r)) |=> flt_code_r == uvf_pkg::FC_SPUR)
        else $error("spurious code missing");
endmodule
`default_nettype wire

//--- core/uvf_pkg.sv
// Package of constants and types for the UV fire detection supervisor
package uvf_pkg;
    localparam int NUM_DET_MAX = 8;
    localparam int CLK_HZ      = 125000000;
    // Rate window is one second; counts compare directly against counts per second
    localparam int WIN_MS      = 1000;
    localparam int WIN_CYC     = (CLK_HZ / 1000) * WIN_MS;
    // Self-test lamp slot per detector
    localparam int TEST_MS     = 100;
    localparam int TEST_CYC    = (CLK_HZ / 1000) * TEST_MS;
    // Thresholds in counts per second, selected by a two-bit field
    localparam logic [7:0] THR_0 = 8'h19;
    localparam logic [7:0] THR_1 = 8'h32;
    localparam logic [7:0] THR_2 = 8'h4B;
    localparam logic [7:0] THR_3 = 8'h64;
    // Register offsets
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STAT   = 4'h1;
    localparam logic [3:0] REG_IRQST  = 4'h2;
    localparam logic [3:0] REG_IRQMSK = 4'h3;
    localparam logic [3:0] REG_DELAY  = 4'h4;
    localparam logic [3:0] REG_FLTIN  = 4'h5;
    localparam logic [3:0] REG_DISP   = 4'h6;
    // Control fields
    localparam int CTRL_THR_LSB = 0;
    localparam int CTRL_BYPASS  = 2;
    localparam int CTRL_MANUAL  = 3;
    localparam int CTRL_NDET_LSB = 4;
    localparam logic [7:0] CTRL_RST = 8'h70;
    localparam logic [15:0] DELAY_RST = 16'h0005;
    // Interrupt status bits
    localparam int IRQ_INST  = 0;
    localparam int IRQ_TIMED = 1;
    localparam int IRQ_FAULT = 2;
    localparam int IRQ_W     = 3;
    // Fault codes; blank shown as code F
    localparam logic [3:0] FC_SPUR   = 4'h0;
    localparam logic [3:0] FC_DCPWR  = 4'h1;
    localparam logic [3:0] FC_SENS   = 4'h2;
    localparam logic [3:0] FC_MON    = 4'h3;
    localparam logic [3:0] FC_LEADC  = 4'h4;
    localparam logic [3:0] FC_LEADB  = 4'h5;
    localparam logic [3:0] FC_LEADA  = 4'h6;
    localparam logic [3:0] FC_COMP   = 4'h7;
    localparam logic [3:0] FC_INHIB  = 4'h8;
    localparam logic [3:0] FC_BLANK  = 4'hF;
    localparam int FC_NUM = 10;
    typedef enum logic [1:0] {
        UVF_IDLE  = 2'b00,
        UVF_LAMP  = 2'b01,
        UVF_CHECK = 2'b10
    } uvf_test_t;
endpackage

//--- core/uvf_rate_if.sv
// Interface carrying one detector channel's rate results
`timescale 1ns/1ns
`default_nettype none
interface uvf_rate_if;
    logic       win;
    logic [7:0] thr;
    logic       over;
    logic       spur;
    logic       seen;
    logic       pulse;
    modport chan (input win, input thr, input pulse, output over, output spur, output seen);
    modport ctrl (output win, output thr, output pulse, input over, input spur, input seen);
endinterface
`default_nettype wire

//--- core/uvf_rate_chan.sv
// Per-detector discharge counter with threshold comparison
`timescale 1ns/1ns
`default_nettype none
module uvf_rate_chan
(
    input  wire logic clk_i,
    input  wire logic rstn_i,
    uvf_rate_if.chan  rif
);
    logic [7:0] cnt_r;
    logic       over_r;
    logic       spur_r;
    logic       seen_r;

    // Saturating count so a burst cannot wrap below the threshold
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            cnt_r <= 8'h00;
        else if (rif.win)
            cnt_r <= rif.pulse ? 8'h01 : 8'h00;
        else if (rif.pulse && cnt_r != 8'hFF)
            cnt_r <= cnt_r + 8'h01;
    end

    // Rate compared at each window end; over holds for the whole next window
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            over_r <= 1'b0;
            spur_r <= 1'b0;
        end
        else if (rif.win)
        begin
            over_r <= cnt_r > rif.thr;
            spur_r <= cnt_r != 8'h00 && cnt_r <= rif.thr;
        end
    end

    // Any pulse in a window counts as a response to the test lamp
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            seen_r <= 1'b0;
        else if (rif.win)
            seen_r <= 1'b0;
        else if (rif.pulse)
            seen_r <= 1'b1;
    end

    assign rif.over = over_r;
    assign rif.spur = spur_r;
    assign rif.seen = seen_r;
endmodule
`default_nettype wire

//--- bench/uvf_det_model.sv
// Behavioural model of the UV detector tubes and their built-in test lamps
`timescale 1ns/1ns
`default_nettype none
module uvf_det_model
#(
    parameter int N = 8
)
(
    input  wire logic         clk_i,
    input  wire logic [N-1:0] lamp_i,
    input  wire logic [N-1:0] blind_i,
    input  wire logic [N-1:0] fire_i,
    input  wire logic [7:0]   per_i,
    output logic      [N-1:0] pulse_o
);
    logic [7:0] cnt_r;
    initial cnt_r = 8'h00;
    always @(posedge clk_i)
    begin
        cnt_r <= (cnt_r + 8'h01 >= per_i) ? 8'h00 : cnt_r + 8'h01;
    end
    // A dirty window stops the lamp light reaching the tube; a flame still gets through
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            pulse_o[i] = (fire_i[i] && cnt_r < (per_i >> 1)) || (lamp_i[i] && !blind_i[i] && cnt_r[1]);
        end
    end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking testbench for the UV fire detection supervisor
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int ND = 8;
    localparam int WC = 400;
    logic          clk_i;
    logic          rstn_i;
    logic [ND-1:0] det_pulse;
    logic          sel_btn;
    logic          test_btn;
    logic [3:0]    reg_addr;
    logic [15:0]   reg_wdata;
    logic          reg_wr;
    logic          reg_rd;
    logic [15:0]   reg_rdata;
    logic [ND-1:0] test_lamp;
    logic          inst_relay;
    logic          timed_relay;
    logic          fault_relay;
    logic [3:0]    disp_right;
    logic [7:0]    disp_left;
    logic          irq;
    logic [ND-1:0] blind;
    logic [ND-1:0] fire;
    logic [7:0]    per;
    logic [15:0]   rd_v;
    int            miscompares;
    int            n_tests;

    uvf_supervisor #(.NUM_DET(ND), .WIN_CYC(WC), .TEST_CYC(50)) uut (
        .clk_i(clk_i), .rstn_i(rstn_i), .det_pulse_i(det_pulse), .sel_btn_i(sel_btn),
        .test_btn_i(test_btn), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .test_lamp_o(test_lamp), .inst_relay_o(inst_relay),
        .timed_relay_o(timed_relay), .fault_relay_o(fault_relay), .disp_right_o(disp_right),
        .disp_left_o(disp_left), .irq_o(irq));
    uvf_det_model #(.N(ND)) det (.clk_i(clk_i), .lamp_i(test_lamp), .blind_i(blind), .fire_i(fire),
        .per_i(per), .pulse_o(det_pulse));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_i);
        reg_wr    <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a);
        @(posedge clk_i);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_i);
        reg_rd   <= 1'b0;
        #1;
        rd_v = reg_rdata;
    endtask
    function automatic logic sig(input int s);
        return (s == 0) ? inst_relay : (s == 1) ? timed_relay : fault_relay;
    endfunction
    // Bounded wait so a dead output cannot hang the run
    task automatic wait_sig(input int s, input logic v, input int lim);
        for (int k = 0; k < lim && sig(s) !== v; k++)
        begin
            @(posedge clk_i);
            #1;
        end
    endtask
    task automatic clear_latch();
        reg_write(uvf_pkg::REG_CTRL, 16'h0074);
        repeat (4) @(posedge clk_i);
        #1;
        check(16'(disp_right), 16'h0008);
        check(16'(disp_left), 16'h0007);
        check(16'(fault_relay), 16'h0000);
        reg_write(uvf_pkg::REG_CTRL, 16'h0070);
        repeat (4) @(posedge clk_i);
    endtask

    task automatic t_reset_idle();
        logic [ND-1:0] lamps;
        logic          rel;
        lamps = '0;
        rel = 1'b0;
        reg_read(uvf_pkg::REG_CTRL);
        check(rd_v, 16'h0070);
        reg_read(uvf_pkg::REG_DELAY);
        check(rd_v, 16'h0005);
        reg_write(4'hF, 16'hFFFF);
        reg_read(4'hF);
        check(rd_v, 16'h0000);
        repeat (16 * WC)
        begin
            @(posedge clk_i);
            lamps = lamps | test_lamp;
            rel = rel | inst_relay | timed_relay;
        end
        check(16'(lamps), 16'h00FF);
        check(16'(rel), 16'h0000);
        check(16'(fault_relay), 16'h0001);
    endtask
    task automatic t_manual();
        test_btn <= 1'b1;
        repeat (8) @(posedge clk_i);
        check(16'(disp_right), 16'h0000);
        check(16'(test_lamp), 16'h0001);
        sel_btn <= 1'b1;
        repeat (8) @(posedge clk_i);
        sel_btn <= 1'b0;
        repeat (8) @(posedge clk_i);
        check(16'(disp_right), 16'h0001);
        check(16'(test_lamp), 16'h0002);
        test_btn <= 1'b0;
        repeat (3 * WC) @(posedge clk_i);
    endtask
    task automatic t_fire_timed();
        logic seen;
        seen = 1'b0;
        reg_write(uvf_pkg::REG_DELAY, 16'h0002);
        reg_write(uvf_pkg::REG_IRQMSK, 16'h0001);
        reg_write(uvf_pkg::REG_IRQST, 16'h0007);
        per  <= 8'h04;
        fire <= 8'h01;
        wait_sig(0, 1'b1, 6 * WC);
        fire <= 8'h00;
        check(16'(inst_relay), 16'h0001);
        check(16'(timed_relay), 16'h0000);
        repeat (6 * WC)
        begin
            @(posedge clk_i);
            seen = seen | timed_relay;
        end
        check(16'(seen), 16'h0000);
        check(16'(irq), 16'h0001);
        reg_read(uvf_pkg::REG_IRQST);
        check(rd_v & 16'h0003, 16'h0001);
        reg_write(uvf_pkg::REG_IRQMSK, 16'h0000);
        repeat (2) @(posedge clk_i);
        check(16'(irq), 16'h0000);
        reg_write(uvf_pkg::REG_IRQST, 16'h0007);
        reg_read(uvf_pkg::REG_IRQST);
        check(rd_v & 16'h0003, 16'h0000);
        fire <= 8'h01;
        wait_sig(1, 1'b1, 12 * WC);
        check(16'(timed_relay), 16'h0001);
        fire <= 8'h00;
        wait_sig(0, 1'b0, 4 * WC);
    endtask
    task automatic t_threshold();
        // 66 or 67 counts a window: above 25 and 50, below 75 and 100
        for (int t = 0; t < 4; t++)
        begin
            reg_write(uvf_pkg::REG_CTRL, 16'h0070 | 16'(t));
            per  <= 8'h06;
            fire <= 8'h02;
            wait_sig(0, 1'b1, 6 * WC);
            check(16'(inst_relay), (t < 2) ? 16'h0001 : 16'h0000);
            fire <= 8'h00;
            wait_sig(0, 1'b0, 4 * WC);
        end
        // Let the spurious verdicts of the last burst age out before faults are latched
        repeat (3 * WC) @(posedge clk_i);
    endtask
    task automatic t_faults();
        logic [3:0] code;
        for (int b = 1; b <= 8; b++)
        begin
            if (b != 2)
            begin
                code = (b == 8) ? uvf_pkg::FC_BLANK : 4'(b);
                clear_latch();
                reg_write(uvf_pkg::REG_FLTIN, 16'h0001 << b);
                wait_sig(2, 1'b0, 16);
                check(16'(disp_right), 16'(code));
                check(16'(fault_relay), 16'h0000);
                reg_write(uvf_pkg::REG_FLTIN, (16'h0001 << b) | ((b == 1) ? 16'h0008 : 16'h0002));
                repeat (4) @(posedge clk_i);
                check(16'(disp_right), 16'(code));
                reg_write(uvf_pkg::REG_FLTIN, 16'h0000);
            end
        end
    endtask
    task automatic t_spur_blind();
        clear_latch();
        per  <= 8'h28;
        fire <= 8'h04;
        wait_sig(2, 1'b0, 6 * WC);
        check(16'(disp_right), 16'(uvf_pkg::FC_SPUR));
        fire <= 8'h00;
        repeat (3 * WC) @(posedge clk_i);
        clear_latch();
        blind <= 8'h08;
        wait_sig(2, 1'b0, 20 * WC);
        check(16'(disp_right), 16'(uvf_pkg::FC_SENS));
        // Left digit follows the latched code, one edge after the relay
        @(posedge clk_i);
        #1;
        check(16'(disp_left), 16'h0008);
        blind <= 8'h00;
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // Whole sequence needs about 25000 cycles, under 48000 even if every wait runs to its limit
    initial
    begin
        repeat (100000) @(posedge clk_i);
        miscompares++;
        end_of_test();
    end
    initial
    begin
        miscompares = 0;
        n_tests     = 0;
        rstn_i      = 1'b0;
        sel_btn     = 1'b0;
        test_btn    = 1'b0;
        reg_addr    = 4'h0;
        reg_wdata   = 16'h0000;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        blind       = '0;
        fire        = '0;
        per         = 8'h04;
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_reset_idle();
        t_manual();
        t_fire_timed();
        t_threshold();
        t_faults();
        t_spur_blind();
        end_of_test();
    end
endmodule
`default_nettype wire
